/* File: pkg/cmpctl_pkg.sv */
// package: register map, fields and reset values of the comparator control
package cmpctl_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] CMP_CTRL_ADDR = 8'h9b;
   localparam logic [7:0] CMP_MODE_ADDR = 8'h9d;
   localparam logic [7:0] CMP_ISEL_ADDR = 8'h9f;
   localparam logic [7:0] CMP_STAT_ADDR = 8'ha0;
   localparam logic [7:0] CMP_MASK_ADDR = 8'ha1;
   localparam logic [7:0] CMP_CTRL_RST  = 8'h00;
   localparam logic [7:0] CMP_ISEL_RST  = 8'h77;
   localparam logic [7:0] CMP_MODE_RST  = 8'h02;
   localparam logic [1:0] CMP_EVT_RST   = 2'h0;
   localparam int unsigned ON_BIT     = 7;
   localparam int unsigned RESULT_BIT = 6;
   localparam int unsigned RISE_BIT   = 5;
   localparam int unsigned FALL_BIT   = 4;
   localparam int unsigned PHYS_HI    = 3;
   localparam int unsigned PHYS_LO    = 2;
   localparam int unsigned NHYS_HI    = 1;
   localparam int unsigned NHYS_LO    = 0;
   localparam int unsigned NSEL_HI    = 7;
   localparam int unsigned NSEL_LO    = 4;
   localparam int unsigned PSEL_HI    = 3;
   localparam int unsigned PSEL_LO    = 0;
   localparam int unsigned RIE_BIT    = 5;
   localparam int unsigned FIE_BIT    = 4;
   localparam int unsigned RMODE_HI   = 1;
   localparam int unsigned RMODE_LO   = 0;
   localparam int unsigned EV_RISE    = 1;
   localparam int unsigned EV_FALL    = 0;
endpackage

/* File: pkg/cmpctl_sync_if.sv */
// interface: raw comparator level in, synchronised level out
`timescale 1ns/1ps
`default_nettype none
interface cmpctl_sync_if;
   logic async_lvl;
   logic sync_lvl;
   modport syncer (input async_lvl, output sync_lvl);
   modport user   (output async_lvl, input sync_lvl);
endinterface
`default_nettype wire

/* File: core/cmpctl_sync.sv */
// three-stage synchroniser; a change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cmpctl_sync (
   input  wire logic        clk_i,   // system clock
   input  wire logic        rst_b_i, // async reset, active low
   cmpctl_sync_if.syncer    sif      // level in and out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic out_r;
   wire  agree = (s2_r == s3_r);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         out_r <= 1'b0;
      end else begin
         s1_r <= sif.async_lvl;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            out_r <= s3_r;
         end
      end
   end

   assign sif.sync_lvl = out_r;
endmodule
`default_nettype wire

/* File: core/cmpctl_top.sv */
// comparator control: registers, edge flags, interrupt and pin outputs
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - falling comparator edge sets fall flag
// - rising comparator edge sets rise flag
// - edge flags sticky until software writes zero
// - result bit six shows live comparator state
// - bit seven enables comparator, else powered down
// - disabled comparator drives pin output low
// - enabled and output low requests oscillator wake
// - clocked latched output plus raw asynchronous output
// - positive hysteresis field bits three to two
// - negative hysteresis field bits one to zero
// - upper nibble selects negative comparator input
// - lower nibble selects positive comparator input
// - rising and falling edges raise interrupt
// - comparator output offered to reset logic
// - mode register holds per-edge interrupt enables
// - mode register response field, reset value 10
module cmpctl_top
   import cmpctl_pkg::*;
(
   input  wire logic              clk_i,          // system clock
   input  wire logic              rst_b_i,        // async reset, active low
   input  wire logic [ADDR_W-1:0] addr_i,         // register address
   input  wire logic [DATA_W-1:0] wdata_i,        // write data
   input  wire logic              wr_i,           // write strobe
   input  wire logic              rd_i,           // read strobe
   output logic      [DATA_W-1:0] rdata_o,        // read data, next cycle
   input  wire logic              comp_raw_i,     // analog core result
   output logic                   comp_on_o,      // analog core enable
   output logic      [1:0]        pos_hyst_o,     // positive hysteresis
   output logic      [1:0]        neg_hyst_o,     // negative hysteresis
   output logic      [3:0]        pos_sel_o,      // positive input select
   output logic      [3:0]        neg_sel_o,      // negative input select
   output logic      [1:0]        resp_mode_o,    // response time mode
   output logic                   latched_comp_o, // clocked pin output
   output logic                   raw_comp_o,     // async pin output
   output logic                   osc_wake_o,     // oscillator wake request
   output logic                   rst_src_o,      // result to reset logic
   output logic                   cmp_irq_o       // level interrupt
);
   logic [7:0] ctrl_r;
   logic [7:0] isel_r;
   logic [7:0] mode_r;
   logic [1:0] evt_r;
   logic [1:0] evt_nxt;
   logic [1:0] mask_r;
   logic [1:0] mask_nxt;
   logic [1:0] flag_nxt;
   logic [7:0] rdata_r;
   logic       prev_r;
   logic       latched_r;
   logic       wake_r;
   logic       rst_src_r;
   logic       irq_r;
   logic       raw_r;

   cmpctl_sync_if sif ();

   // raw core result gated off while disabled
   assign sif.async_lvl = comp_raw_i & ctrl_r[ON_BIT];
   cmpctl_sync u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .sif     (sif)
   );

   wire       cur     = sif.sync_lvl;
   wire       rise    = cur & ~prev_r;
   wire       fall    = ~cur & prev_r;
   wire       wr_ctrl = wr_i && (addr_i == CMP_CTRL_ADDR);
   wire       wr_isel = wr_i && (addr_i == CMP_ISEL_ADDR);
   wire       wr_mode = wr_i && (addr_i == CMP_MODE_ADDR);
   wire       wr_stat = wr_i && (addr_i == CMP_STAT_ADDR);
   wire       wr_mask = wr_i && (addr_i == CMP_MASK_ADDR);
   wire [1:0] new_evt = {rise & mode_r[RIE_BIT],
                         fall & mode_r[FIE_BIT]};

   // flags: hardware set wins over software zero-write
   wire [1:0] flag_cur = {ctrl_r[RISE_BIT], ctrl_r[FALL_BIT]};
   wire [1:0] flag_wr  = {wdata_i[RISE_BIT], wdata_i[FALL_BIT]};
   wire [1:0] flag_hw  = {rise, fall};
   always_comb begin
      flag_nxt = wr_ctrl ? flag_wr : flag_cur;
      flag_nxt = flag_nxt | flag_hw;
      evt_nxt  = evt_r;
      if (wr_stat) begin
         evt_nxt = evt_r & ~wdata_i[1:0];
      end
      evt_nxt  = evt_nxt | new_evt;
      mask_nxt = wr_mask ? wdata_i[1:0] : mask_r;
   end

   wire [7:0] ctrl_rd = {ctrl_r[ON_BIT], cur, ctrl_r[5:0]};
   wire [7:0] mode_rd = {2'h0, mode_r[RIE_BIT], mode_r[FIE_BIT],
                         2'h0, mode_r[RMODE_HI:RMODE_LO]};
   wire [7:0] rd_mux  =
      (addr_i == CMP_CTRL_ADDR) ? ctrl_rd :
      (addr_i == CMP_ISEL_ADDR) ? isel_r :
      (addr_i == CMP_MODE_ADDR) ? mode_rd :
      (addr_i == CMP_STAT_ADDR) ? {6'h00, evt_r} :
      (addr_i == CMP_MASK_ADDR) ? {6'h00, mask_r} : 8'h00;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= CMP_CTRL_RST;
         isel_r <= CMP_ISEL_RST;
         mode_r <= CMP_MODE_RST;
         evt_r  <= CMP_EVT_RST;
         mask_r <= CMP_EVT_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[ON_BIT]          <= wdata_i[ON_BIT];
            ctrl_r[PHYS_HI:NHYS_LO] <= wdata_i[PHYS_HI:NHYS_LO];
         end
         ctrl_r[RESULT_BIT] <= 1'b0;
         ctrl_r[RISE_BIT]   <= flag_nxt[EV_RISE];
         ctrl_r[FALL_BIT]   <= flag_nxt[EV_FALL];
         if (wr_isel) begin
            isel_r <= wdata_i;
         end
         if (wr_mode) begin
            mode_r <= {2'h0, wdata_i[RIE_BIT], wdata_i[FIE_BIT],
                       2'h0, wdata_i[RMODE_HI:RMODE_LO]};
         end
         evt_r  <= evt_nxt;
         mask_r <= mask_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r   <= 8'h00;
         prev_r    <= 1'b0;
         latched_r <= 1'b0;
         wake_r    <= 1'b0;
         rst_src_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         rdata_r   <= rd_i ? rd_mux : 8'h00;
         prev_r    <= cur;
         latched_r <= cur & ctrl_r[ON_BIT];
         wake_r    <= ctrl_r[ON_BIT] & ~cur;
         rst_src_r <= cur;
         irq_r     <= |(evt_nxt & mask_nxt);
      end
   end

   // raw path must keep running with the clock stopped: no clocked stage
   assign raw_r = comp_raw_i & ctrl_r[ON_BIT];

   assign rdata_o        = rdata_r;
   assign comp_on_o      = ctrl_r[ON_BIT];
   assign pos_hyst_o     = ctrl_r[PHYS_HI:PHYS_LO];
   assign neg_hyst_o     = ctrl_r[NHYS_HI:NHYS_LO];
   assign pos_sel_o      = isel_r[PSEL_HI:PSEL_LO];
   assign neg_sel_o      = isel_r[NSEL_HI:NSEL_LO];
   assign resp_mode_o    = mode_r[RMODE_HI:RMODE_LO];
   assign latched_comp_o = latched_r;
   assign raw_comp_o     = raw_r;
   assign osc_wake_o     = wake_r;
   assign rst_src_o      = rst_src_r;
   assign cmp_irq_o      = irq_r;
endmodule
`default_nettype wire

/* File: verification/cmpctl_partner.sv */
// model of the analog comparator core behind the block
`timescale 1ns/1ps
`default_nettype none
module cmpctl_partner (
   input  wire logic clk_i,     // system clock
   input  wire logic comp_on_i, // enable from block
   input  wire logic lvl_i,     // 1 while positive input above negative
   output logic      comp_raw_o // result to block
);
   logic tog_r = 1'b0;
   // powered down the result means nothing, so it wanders
   always @(posedge clk_i) tog_r <= ~tog_r;
   assign comp_raw_o = comp_on_i ? lvl_i : tog_r;
endmodule
`default_nettype wire

/* File: verification/cmpctl_checker.sv */
// port assertions of the comparator control
`timescale 1ns/1ps
`default_nettype none
module cmpctl_checker
   import cmpctl_pkg::*;
(
   input wire logic clk_i, rst_b_i, wr_i, rd_i, comp_raw_i, comp_on_o,
   input wire logic [7:0] addr_i, wdata_i, rdata_o,
   input wire logic [1:0] pos_hyst_o, neg_hyst_o, resp_mode_o,
   input wire logic [3:0] pos_sel_o, neg_sel_o,
   input wire logic latched_comp_o, raw_comp_o, osc_wake_o, rst_src_o,
   input wire logic cmp_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic wc, wm, ws;
   assign wc = wr_i && addr_i == CMP_CTRL_ADDR;
   assign wm = wr_i && addr_i == CMP_MODE_ADDR;
   assign ws = wr_i && addr_i == CMP_ISEL_ADDR;
   property p_on; wc |=> comp_on_o == $past(wdata_i[7]); endproperty
   a_on: assert property (p_on) else $error("enable bit lost");
   property p_hyst;
      wc |=> {pos_hyst_o, neg_hyst_o} == $past(wdata_i[3:0]);
   endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis lost");
   property p_sel; ws |=> {neg_sel_o, pos_sel_o} == $past(wdata_i); endproperty
   a_sel: assert property (p_sel) else $error("input select lost");
   property p_resp; wm |=> resp_mode_o == $past(wdata_i[1:0]); endproperty
   a_resp: assert property (p_resp) else $error("response mode lost");
   property p_raw; raw_comp_o == (comp_raw_i && comp_on_o); endproperty
   a_raw: assert property (p_raw) else $error("raw output wrong");
   property p_off; !comp_on_o && !$past(comp_on_o) |-> !latched_comp_o;
   endproperty
   a_off: assert property (p_off) else $error("latched high while off");
   property p_wake;
      comp_on_o && $past(comp_on_o) |-> osc_wake_o == !rst_src_o;
   endproperty
   a_wake: assert property (p_wake) else $error("wake request wrong");
   property p_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
endmodule
bind cmpctl_top cmpctl_checker i_cmpctl_checker (
   .clk_i          (clk_i),
   .rst_b_i        (rst_b_i),
   .wr_i           (wr_i),
   .rd_i           (rd_i),
   .comp_raw_i     (comp_raw_i),
   .comp_on_o      (comp_on_o),
   .addr_i         (addr_i),
   .wdata_i        (wdata_i),
   .rdata_o        (rdata_o),
   .pos_hyst_o     (pos_hyst_o),
   .neg_hyst_o     (neg_hyst_o),
   .resp_mode_o    (resp_mode_o),
   .pos_sel_o      (pos_sel_o),
   .neg_sel_o      (neg_sel_o),
   .latched_comp_o (latched_comp_o),
   .raw_comp_o     (raw_comp_o),
   .osc_wake_o     (osc_wake_o),
   .rst_src_o      (rst_src_o),
   .cmp_irq_o      (cmp_irq_o)
);
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the comparator control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cmpctl_pkg::*;
   logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, lvl = 0;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, rv;
   logic comp_raw_i, comp_on_o, latched_comp_o, raw_comp_o, osc_wake_o;
   logic rst_src_o, cmp_irq_o;
   logic [1:0] pos_hyst_o, neg_hyst_o, resp_mode_o;
   logic [3:0] pos_sel_o, neg_sel_o;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   cmpctl_top i_cmpctl_top (.*);
   cmpctl_partner i_cmpctl_partner (.clk_i(clk_i), .comp_on_i(comp_on_o),
      .lvl_i(lvl), .comp_raw_o(comp_raw_i));
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, d);
      @(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge clk_i) wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
      @(posedge clk_i) rd_i <= 1'b0;
      #1 rv = rdata_o;
   endtask
   task to_lvl(input logic v);
      @(posedge clk_i) lvl <= v;
      repeat (8) @(posedge clk_i);
      #1;
   endtask
   task t_reset;
      rd(CMP_CTRL_ADDR); chk(rv, 8'h00);
      rd(CMP_ISEL_ADDR); chk(rv, 8'h77);
      rd(CMP_MODE_ADDR); chk(rv, 8'h02);
      rd(8'h9c); chk(rv, 8'h00);
      $display("test reset done");
   endtask
   task t_fields;
      logic [3:0] n;
      for (int i = 0; i < 16; i++) begin
         n = i[3:0];
         wr(CMP_CTRL_ADDR, {4'h0, n});
         chk({4'h0, pos_hyst_o, neg_hyst_o}, {4'h0, n});
         wr(CMP_ISEL_ADDR, {n, ~n});
         chk({neg_sel_o, pos_sel_o}, {n, ~n});
         wr(CMP_MODE_ADDR, {6'h0, n[1:0]});
         chk({6'h0, resp_mode_o}, {6'h0, n[1:0]});
      end
      $display("test fields done");
   endtask
   task t_edges;
      wr(CMP_MODE_ADDR, 8'h32); wr(CMP_MASK_ADDR, 8'h03);
      wr(CMP_CTRL_ADDR, 8'h80); chk1(comp_on_o, 1'b1);
      to_lvl(0);
      wr(CMP_CTRL_ADDR, 8'h80); wr(CMP_STAT_ADDR, 8'h03);
      chk1(cmp_irq_o, 1'b0); chk1(osc_wake_o, 1'b1);
      to_lvl(1);
      rd(CMP_CTRL_ADDR); chk(rv & 8'h70, 8'h60);
      rd(CMP_STAT_ADDR); chk(rv, 8'h02);
      chk1(cmp_irq_o, 1'b1); chk1(osc_wake_o, 1'b0);
      chk1(latched_comp_o, 1'b1); chk1(rst_src_o, 1'b1);
      wr(CMP_STAT_ADDR, 8'h02); chk1(cmp_irq_o, 1'b0);
      to_lvl(0);
      rd(CMP_CTRL_ADDR); chk(rv & 8'h70, 8'h30);
      chk1(cmp_irq_o, 1'b1);
      wr(CMP_MASK_ADDR, 8'h00); chk1(cmp_irq_o, 1'b0);
      wr(CMP_MASK_ADDR, 8'h03); chk1(cmp_irq_o, 1'b1);
      wr(CMP_STAT_ADDR, 8'h01); chk1(cmp_irq_o, 1'b0);
      wr(CMP_MODE_ADDR, 8'h02); wr(CMP_CTRL_ADDR, 8'h80);
      to_lvl(1);
      rd(CMP_STAT_ADDR); chk(rv, 8'h00);
      rd(CMP_CTRL_ADDR); chk(rv & 8'h30, 8'h20);
      wr(CMP_CTRL_ADDR, 8'h80);
      rd(CMP_CTRL_ADDR); chk(rv & 8'h30, 8'h00);
      $display("test edges done");
   endtask
   task t_off;
      wr(CMP_CTRL_ADDR, 8'h00); to_lvl(1);
      chk1(latched_comp_o, 1'b0); chk1(raw_comp_o, 1'b0);
      rd(CMP_CTRL_ADDR); chk(rv & 8'h80, 8'h00);
      $display("test off done");
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset;
      t_fields;
      t_edges;
      t_off;
      wrap_up;
   end
endmodule
`default_nettype wire
